// ===== rtl/spdl_regs.vh
`ifndef SPDL_REGS_VH
`define SPDL_REGS_VH
// Byte addresses of the registers and their aliases
`define SPDL_PLL_CFG_A0 20'h130c4
`define SPDL_PLL_CFG_A1 20'h138c4
`define SPDL_LB_CLK_A0 20'h130c8
`define SPDL_LB_CLK_A1 20'h138c8
`define SPDL_IRQ_STAT 20'h130d0
`define SPDL_IRQ_MASK 20'h130d4
// PLL global configuration fields (bit 31 is field bit 0)
`define SPDL_PRESC_HI 21
`define SPDL_PRESC_LO 20
`define SPDL_PRESC_RST 2'h2
`define SPDL_PRESC_BAD 2'h3
`define SPDL_PRSV_HI 19
`define SPDL_PRSV_LO 8
`define SPDL_PRSV_RST 12'hc05
`define SPDL_FINE_HI 7
`define SPDL_FINE_LO 6
`define SPDL_TAIL_HI 5
`define SPDL_TAIL_LO 0
// Loopback and clock select fields
`define SPDL_TEN_BIT 31
`define SPDL_RLD_HI 30
`define SPDL_RLD_LO 16
`define SPDL_RLD_RST 15'h7fff
`define SPDL_LLB_HI 15
`define SPDL_LLB_LO 12
`define SPDL_LRSV_BIT 11
`define SPDL_MODE_BIT 10
`define SPDL_ODD_BIT 9
`define SPDL_EVEN_BIT 8
// Timer prescale shift (cycles per reload step = 2^13)
`define SPDL_TICK_SHIFT 13
// Interrupt status bit positions
`define SPDL_EV_MULT 4
`define SPDL_EV_CHG 5
`define SPDL_EV_W 6
// AXI responses
`define SPDL_RESP_OK 2'h0
`define SPDL_RESP_ERR 2'h2
`endif

// ===== rtl/spdl_top.v
`timescale 1ns/10ps
`default_nettype none
`include "spdl_regs.vh"
module spdl_top #(
   parameter AW = 20, // AXI address width
   parameter CW = 3, // Coarse multiplier width
   parameter TICK_SHIFT = `SPDL_TICK_SHIFT // Cycles per step, log2
) (
   input wire core_clk, // System clock
   input wire rst_b, // Synchronous reset, active low
   input wire [AW-1:0] s_axi_awaddr, // Write address
   input wire s_axi_awvalid, // Write address valid
   output wire s_axi_awready, // Write address ready
   input wire [31:0] s_axi_wdata, // Write data
   input wire [3:0] s_axi_wstrb, // Write byte strobes
   input wire s_axi_wvalid, // Write data valid
   output wire s_axi_wready, // Write data ready
   output reg [1:0] s_axi_bresp, // Write response
   output reg s_axi_bvalid, // Write response valid
   input wire s_axi_bready, // Write response ready
   input wire [AW-1:0] s_axi_araddr, // Read address
   input wire s_axi_arvalid, // Read address valid
   output wire s_axi_arready, // Read address ready
   output reg [31:0] s_axi_rdata, // Read data
   output reg [1:0] s_axi_rresp, // Read response
   output reg s_axi_rvalid, // Read data valid
   input wire s_axi_rready, // Read data ready
   input wire serdes_in_reset, // Serializer held in reset
   input wire pll_enabled, // Main serializer PLL running
   input wire [CW-1:0] pll_coarse_multiplier, // Coarse multiplier
   input wire [3:0] link_powered, // Per port: powered and enabled
   input wire [3:0] link_silence, // Per port: silence seen, pulse
   input wire [3:0] link_partner_ok, // Per port: partner answered
   input wire [3:0] pkt_valid, // Per port: packet offered
   output wire [3:0] pkt_admit, // Per port: packet enters queue
   output wire [3:0] pkt_drop, // Per port: packet discarded
   output reg [3:0] tx_flush, // Per port: flush queue, pulse
   output reg [3:0] port_dead, // Per port: link declared dead
   output reg [1:0] ref_divider_select, // Reference prescaler
   output reg [1:0] pll_fine_multiplier, // Fine multiplier
   output reg [CW+4:0] pll_mult_factor, // Resulting factor
   output reg silence_timer_enable, // Shared timer enable
   output reg [14:0] silence_timer_reload, // Shared reload value
   output reg [3:0] line_loopback, // Shared line loopback
   output reg mac_mode, // Shared MAC mode
   output reg [3:0] equip_loopback, // Per channel loopback
   output wire irq // Level interrupt
);

   // Write channel holding registers
   reg aw_full_q;
   reg [AW-1:0] aw_addr_q;
   reg w_full_q;
   reg [31:0] w_data_q;
   reg [3:0] w_strb_q;
   // Stored fields with no output of their own
   reg [11:0] pll_rsv_q; // Writable reserved bits 12:23
   reg [5:0] pll_tail_q; // Writable reserved bits 26:31
   reg lb_rsv_q; // Writable reserved bit 20
   reg [`SPDL_EV_W-1:0] irq_stat_q; // Sticky events
   reg [`SPDL_EV_W-1:0] irq_mask_q; // Enables per event
   // Per-port dead-link counters
   reg [TICK_SHIFT+14:0] dl_cnt_q [0:3];
   reg [3:0] dl_run_q;

   wire do_wr; // Write happens this cycle
   wire [31:0] wmask; // Byte strobe expanded
   wire wr_pll; // Either PLL alias
   wire wr_lb0; // Loopback alias for ports 0,1
   wire wr_lb1; // Loopback alias for ports 2,3
   wire wr_stat; // Status register
   wire wr_mask; // Mask register
   wire [31:0] pll_img; // PLL register as read
   wire [31:0] lb_img0; // Loopback register, alias 0
   wire [31:0] lb_img1; // Loopback register, alias 1
   wire [31:0] pll_new; // Merged PLL write value
   wire [31:0] lb_new; // Merged loopback write value
   wire [31:0] st_new; // Merged status write value
   wire [31:0] mk_new; // Merged mask write value
   wire [1:0] presc_new; // Prescaler after merge
   wire [1:0] fine_new; // Fine multiplier after merge
   wire pll_locked_out; // PLL running, settings must not change
   wire timer_on; // Shared timer gate
   wire [3:0] dead_set; // Counter expiry this cycle
   wire [CW:0] coarse_p1; // Coarse plus one
   reg [`SPDL_EV_W-1:0] ev_set; // Events raised this cycle

   // Write channels are accepted while their holder is empty, reads while no read data waits
   assign s_axi_awready = ~aw_full_q;
   assign s_axi_wready = ~w_full_q;
   assign s_axi_arready = ~s_axi_rvalid;
   assign do_wr = aw_full_q & w_full_q & ~s_axi_bvalid;
   assign wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
                   {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

   assign wr_pll = do_wr & (aw_addr_q == `SPDL_PLL_CFG_A0 |
                            aw_addr_q == `SPDL_PLL_CFG_A1);
   assign wr_lb0 = do_wr & (aw_addr_q == `SPDL_LB_CLK_A0);
   assign wr_lb1 = do_wr & (aw_addr_q == `SPDL_LB_CLK_A1);
   assign wr_stat = do_wr & (aw_addr_q == `SPDL_IRQ_STAT);
   assign wr_mask = do_wr & (aw_addr_q == `SPDL_IRQ_MASK);

   assign pll_img = {10'h000, ref_divider_select, pll_rsv_q,
                     pll_fine_multiplier, pll_tail_q};
   assign lb_img0 = {silence_timer_enable, silence_timer_reload,
                     line_loopback, lb_rsv_q, mac_mode,
                     equip_loopback[1], equip_loopback[0], 8'h00};
   assign lb_img1 = {lb_img0[31:10], equip_loopback[3],
                     equip_loopback[2], 8'h00};

   assign pll_new = (pll_img & ~wmask) | (w_data_q & wmask);
   assign lb_new = ((aw_addr_q == `SPDL_LB_CLK_A1 ? lb_img1 : lb_img0)
                    & ~wmask) | (w_data_q & wmask);
   assign st_new = w_data_q & wmask;
   assign mk_new = ({{(32-`SPDL_EV_W){1'b0}}, irq_mask_q} & ~wmask)
                   | (w_data_q & wmask);
   assign presc_new = pll_new[`SPDL_PRESC_HI:`SPDL_PRESC_LO];
   assign fine_new = pll_new[`SPDL_FINE_HI:`SPDL_FINE_LO];
   assign pll_locked_out = ~serdes_in_reset & pll_enabled;
   assign coarse_p1 = {1'b0, pll_coarse_multiplier} + {{CW{1'b0}}, 1'b1};

   // Write response and channel holders
   always @(posedge core_clk) begin
      if (!rst_b) begin
         aw_full_q <= 1'b0;
         aw_addr_q <= {AW{1'b0}};
         w_full_q <= 1'b0;
         w_data_q <= 32'h0;
         w_strb_q <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `SPDL_RESP_OK;
      end else begin
         // Capture address
         if (s_axi_awvalid && !aw_full_q) begin
            aw_full_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         // Capture data
         if (s_axi_wvalid && !w_full_q) begin
            w_full_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         // Commit and answer
         if (do_wr) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (wr_pll | wr_lb0 | wr_lb1 | wr_stat | wr_mask) begin
               s_axi_bresp <= `SPDL_RESP_OK;
            end else begin
               s_axi_bresp <= `SPDL_RESP_ERR;
            end
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Read path, answer one cycle after address
   always @(posedge core_clk) begin
      if (!rst_b) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= `SPDL_RESP_OK;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `SPDL_RESP_OK;
         case (s_axi_araddr)
            `SPDL_PLL_CFG_A0, `SPDL_PLL_CFG_A1: begin
               s_axi_rdata <= pll_img;
            end
            `SPDL_LB_CLK_A0: begin
               s_axi_rdata <= lb_img0;
            end
            `SPDL_LB_CLK_A1: begin
               s_axi_rdata <= lb_img1;
            end
            `SPDL_IRQ_STAT: begin
               s_axi_rdata <= {{(32-`SPDL_EV_W){1'b0}}, irq_stat_q};
            end
            `SPDL_IRQ_MASK: begin
               s_axi_rdata <= {{(32-`SPDL_EV_W){1'b0}}, irq_mask_q};
            end
            default: begin
               s_axi_rdata <= 32'h0;
               s_axi_rresp <= `SPDL_RESP_ERR;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // PLL global configuration storage
   always @(posedge core_clk) begin
      if (!rst_b) begin
         ref_divider_select <= `SPDL_PRESC_RST;
         pll_rsv_q <= `SPDL_PRSV_RST;
         pll_fine_multiplier <= 2'h0;
         pll_tail_q <= 6'h00;
      end else if (wr_pll) begin
         if (presc_new != `SPDL_PRESC_BAD) begin
            ref_divider_select <= presc_new;
         end
         pll_rsv_q <= pll_new[`SPDL_PRSV_HI:`SPDL_PRSV_LO];
         pll_fine_multiplier <= fine_new;
         pll_tail_q <= pll_new[`SPDL_TAIL_HI:`SPDL_TAIL_LO];
      end
   end

   // multiplier from both fields
   // Every operand is widened to the result width on purpose;
   // the largest product, 2 * (4 * 8 + 3), still fits in it
   always @(posedge core_clk) begin
      if (!rst_b) begin
         pll_mult_factor <= {(CW+5){1'b0}};
      end else begin
         pll_mult_factor <= {{(CW+3){1'b0}}, ref_divider_select} *
            ({2'b00, coarse_p1, 2'b00} +
             {{(CW+3){1'b0}}, pll_fine_multiplier});
      end
   end

   // Loopback register: globals and line loopback shared, equipment loopbacks per alias
   always @(posedge core_clk) begin
      if (!rst_b) begin
         silence_timer_enable <= 1'b0;
         silence_timer_reload <= `SPDL_RLD_RST;
         line_loopback <= 4'h0;
         lb_rsv_q <= 1'b0;
         mac_mode <= 1'b0;
         equip_loopback <= 4'h0;
      end else if (wr_lb0 || wr_lb1) begin
         silence_timer_enable <= lb_new[`SPDL_TEN_BIT];
         silence_timer_reload <= lb_new[`SPDL_RLD_HI:`SPDL_RLD_LO];
         line_loopback <= lb_new[`SPDL_LLB_HI:`SPDL_LLB_LO];
         lb_rsv_q <= lb_new[`SPDL_LRSV_BIT];
         mac_mode <= lb_new[`SPDL_MODE_BIT];
         if (wr_lb1) begin
            equip_loopback[3] <= lb_new[`SPDL_ODD_BIT];
            equip_loopback[2] <= lb_new[`SPDL_EVEN_BIT];
         end else begin
            equip_loopback[1] <= lb_new[`SPDL_ODD_BIT];
            equip_loopback[0] <= lb_new[`SPDL_EVEN_BIT];
         end
      end
   end

   assign timer_on = silence_timer_enable & (silence_timer_reload != 15'h0);

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_port
         assign dead_set[gi] = dl_run_q[gi] &
            (dl_cnt_q[gi] == {(TICK_SHIFT+15){1'b0}});
         assign pkt_admit[gi] = pkt_valid[gi] & ~port_dead[gi];
         assign pkt_drop[gi] = pkt_valid[gi] & port_dead[gi];

         // Countdown and dead state for one port
         always @(posedge core_clk) begin
            if (!rst_b) begin
               dl_cnt_q[gi] <= {(TICK_SHIFT+15){1'b0}};
               dl_run_q[gi] <= 1'b0;
               port_dead[gi] <= 1'b0;
               tx_flush[gi] <= 1'b0;
            end else begin
               tx_flush[gi] <= 1'b0;
               if (!timer_on || !link_powered[gi] ||
                   link_partner_ok[gi]) begin
                  // Partner answered, link unpowered or timer off: link alive
                  dl_run_q[gi] <= 1'b0;
                  port_dead[gi] <= 1'b0;
               end else if (link_silence[gi] && !port_dead[gi]) begin
                  dl_cnt_q[gi] <= {silence_timer_reload,
                                   {TICK_SHIFT{1'b1}}};
                  dl_run_q[gi] <= 1'b1;
               end else if (dead_set[gi]) begin
                  dl_run_q[gi] <= 1'b0;
                  port_dead[gi] <= 1'b1;
                  tx_flush[gi] <= 1'b1;
               end else if (dl_run_q[gi]) begin
                  dl_cnt_q[gi] <= dl_cnt_q[gi] -
                     {{(TICK_SHIFT+14){1'b0}}, 1'b1};
               end
            end
         end
      end
   endgenerate

   // Events raised this cycle
   always @* begin
      ev_set = {`SPDL_EV_W{1'b0}};
      ev_set[3:0] = dead_set;
      ev_set[`SPDL_EV_MULT] = wr_pll &
         (coarse_p1 < {{(CW-1){1'b0}}, fine_new});
      ev_set[`SPDL_EV_CHG] = wr_pll & pll_locked_out &
         ((presc_new != ref_divider_select) |
          (fine_new != pll_fine_multiplier));
   end

   // Sticky status, write one to clear, set wins
   always @(posedge core_clk) begin
      if (!rst_b) begin
         irq_stat_q <= {`SPDL_EV_W{1'b0}};
         irq_mask_q <= {`SPDL_EV_W{1'b0}};
      end else begin
         if (wr_stat) begin
            irq_stat_q <= (irq_stat_q & ~st_new[`SPDL_EV_W-1:0]) | ev_set;
         end else begin
            irq_stat_q <= irq_stat_q | ev_set;
         end
         if (wr_mask) begin
            irq_mask_q <= mk_new[`SPDL_EV_W-1:0];
         end
      end
   end

   // Interrupt while any unmasked event is pending
   assign irq = |(irq_stat_q & irq_mask_q);

endmodule
`default_nettype wire

// ===== tb/spdl_properties.sv
`timescale 1ns/10ps
`default_nettype none
module spdl_properties #(
   parameter CW = 3, // Coarse multiplier width
   parameter TICK_SHIFT = 13 // Timer step, log2
) (
   input wire logic core_clk, // Clock
   input wire logic rst_b, // Reset, active low
   input wire logic s_axi_arvalid, // Read address valid
   input wire logic s_axi_arready, // Read address ready
   input wire logic s_axi_rvalid, // Read data valid
   input wire logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [CW-1:0] pll_coarse_multiplier, // Coarse
   input wire logic [3:0] link_powered, // Link up
   input wire logic [3:0] link_silence, // Silence pulse
   input wire logic [3:0] link_partner_ok, // Partner answers
   input wire logic [3:0] pkt_valid, // Packet offered
   input wire logic [3:0] pkt_admit, // Packet admitted
   input wire logic [3:0] pkt_drop, // Packet dropped
   input wire logic [3:0] tx_flush, // Queue flush
   input wire logic [3:0] port_dead, // Link dead
   input wire logic [1:0] ref_divider_select, // Prescaler
   input wire logic [1:0] pll_fine_multiplier, // Fine multiplier
   input wire logic [CW+4:0] pll_mult_factor, // Factor
   input wire logic silence_timer_enable, // Timer enable
   input wire logic [14:0] silence_timer_reload // Reload value
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   logic [31:0] since_q; // Edges since port 0 timer start
   wire start0; // Silence that arms port 0
   assign start0 = link_silence[0] && silence_timer_enable &&
      (|silence_timer_reload) && link_powered[0] &&
      !link_partner_ok[0] && !port_dead[0];
   // Count from the arming silence
   always @(posedge core_clk) begin
      if (!rst_b || start0) begin
         since_q <= 32'h0;
      end else begin
         since_q <= since_q + 32'h1;
      end
   end
   sequence s_rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   property p_rst_vals;
      $rose(rst_b) |-> !silence_timer_enable &&
         silence_timer_reload == 15'h7fff && ref_divider_select == 2'h2;
   endproperty
   property p_presc;
      ref_divider_select != 2'h3;
   endproperty
   property p_admit;
      pkt_admit == (pkt_valid & ~port_dead) &&
         pkt_drop == (pkt_valid & port_dead);
   endproperty
   property p_flush;
      tx_flush == (port_dead & ~$past(port_dead));
   endproperty
   property p_off;
      !(silence_timer_enable && |silence_timer_reload) |=> port_dead == 4'h0;
   endproperty
   property p_time;
      $rose(port_dead[0]) |->
         since_q == ((32'(silence_timer_reload) + 1) << TICK_SHIFT);
   endproperty
   property p_mult;
      $past(rst_b) |-> 32'(pll_mult_factor) ==
         32'($past(ref_divider_select)) *
         (4 * (32'($past(pll_coarse_multiplier)) + 1) +
         32'($past(pll_fine_multiplier)));
   endproperty
   property p_rd;
      s_rd_taken |=> s_axi_rvalid;
   endproperty
   property p_bdone;
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
   endproperty
   a_rst_vals: assert property (p_rst_vals)
      else $error("reset values wrong");
   a_presc: assert property (p_presc)
      else $error("prescaler holds unused code");
   a_admit: assert property (p_admit)
      else $error("admit or drop wrong");
   a_flush: assert property (p_flush)
      else $error("flush not tied to dead rise");
   a_off: assert property (p_off)
      else $error("dead while timer off");
   a_time: assert property (p_time)
      else $error("timeout length wrong");
   a_mult: assert property (p_mult)
      else $error("multiplication factor wrong");
   a_rd: assert property (p_rd)
      else $error("read not answered");
   a_bdone: assert property (p_bdone)
      else $error("write response not retired");
endmodule
`default_nettype wire

// ===== tb/spdl_link_partner.sv
`timescale 1ns/10ps
`default_nettype none
module spdl_link_partner (
   input wire logic core_clk, // Clock
   input wire logic [3:0] mute, // Partner goes quiet
   output logic [3:0] link_silence, // Silence seen, pulse
   output logic [3:0] link_partner_ok // Partner answering
);
   logic [3:0] mute_q; // Mute of last cycle
   // Quiet partner stops answering; silence flagged once
   always @(posedge core_clk) begin
      mute_q <= mute;
      link_silence <= mute & ~mute_q;
      link_partner_ok <= ~mute;
   end
endmodule
`default_nettype wire

// ===== tb/spdl_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "spdl_regs.vh"
module spdl_top_tb;
   logic core_clk, rst_b; // Clock and reset
   logic [19:0] s_axi_awaddr, s_axi_araddr; // Addresses
   logic s_axi_awvalid, s_axi_wvalid, s_axi_bready; // Write side
   logic s_axi_arvalid, s_axi_rready; // Read side
   logic [31:0] s_axi_wdata; // Write data
   logic [3:0] s_axi_wstrb; // Byte strobes
   logic serdes_in_reset, pll_enabled; // PLL state
   logic [2:0] pll_coarse_multiplier; // Coarse multiplier
   logic [3:0] link_powered, pkt_valid, mute; // Lane controls
   wire s_axi_awready, s_axi_wready, s_axi_bvalid;
   wire s_axi_arready, s_axi_rvalid, silence_timer_enable;
   wire mac_mode, irq;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [3:0] link_silence, link_partner_ok, pkt_admit, pkt_drop;
   wire [3:0] tx_flush, port_dead, line_loopback, equip_loopback;
   wire [1:0] ref_divider_select, pll_fine_multiplier;
   wire [7:0] pll_mult_factor;
   wire [14:0] silence_timer_reload;
   int mismatches, checks_done; // Tallies
   logic [31:0] rd; // Last read data
   logic [1:0] rs; // Last response
   spdl_top #(.TICK_SHIFT(2)) spdl_top_inst (
      .core_clk(core_clk), .rst_b(rst_b),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .serdes_in_reset(serdes_in_reset),
      .pll_enabled(pll_enabled),
      .pll_coarse_multiplier(pll_coarse_multiplier),
      .link_powered(link_powered), .link_silence(link_silence),
      .link_partner_ok(link_partner_ok), .pkt_valid(pkt_valid),
      .pkt_admit(pkt_admit), .pkt_drop(pkt_drop), .tx_flush(tx_flush),
      .port_dead(port_dead), .ref_divider_select(ref_divider_select),
      .pll_fine_multiplier(pll_fine_multiplier),
      .pll_mult_factor(pll_mult_factor),
      .silence_timer_enable(silence_timer_enable),
      .silence_timer_reload(silence_timer_reload),
      .line_loopback(line_loopback), .mac_mode(mac_mode),
      .equip_loopback(equip_loopback), .irq(irq));
   spdl_link_partner spdl_link_partner_inst (.core_clk(core_clk),
      .mute(mute), .link_silence(link_silence),
      .link_partner_ok(link_partner_ok));
   // Compare and count
   task automatic chk(input logic [31:0] got, exp, input string nm);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // AXI write, response checked
   task automatic wr(input logic [19:0] a, input logic [31:0] d,
      input logic [1:0] er);
      logic aw, w, b;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(negedge core_clk);
         aw = s_axi_awvalid && s_axi_awready;
         w = s_axi_wvalid && s_axi_wready;
         b = s_axi_bvalid;
         rs = s_axi_bresp;
         @(posedge core_clk);
         if (aw) s_axi_awvalid <= 1'b0;
         if (w) s_axi_wvalid <= 1'b0;
      end while (!b);
      s_axi_bready <= 1'b0;
      @(posedge core_clk);
      chk(rs, er, "bresp");
   endtask
   // AXI read, data and response checked
   task automatic rdc(input logic [19:0] a, input logic [31:0] exp,
      input logic [1:0] er, input string nm);
      logic t, b;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(negedge core_clk);
         t = s_axi_arready;
         b = s_axi_rvalid;
         rd = s_axi_rdata;
         rs = s_axi_rresp;
         @(posedge core_clk);
         if (t) s_axi_arvalid <= 1'b0;
      end while (!b);
      s_axi_rready <= 1'b0;
      @(posedge core_clk);
      chk(rd, exp, nm);
      chk(rs, er, nm);
   endtask
   task automatic t_reset;
      chk(silence_timer_enable, 0, "timer_en");
      chk(silence_timer_reload, 15'h7fff, "reload");
      rdc(`SPDL_PLL_CFG_A0, 32'h002c0500, 2'h0, "pll_rst");
      rdc(`SPDL_LB_CLK_A0, 32'h7fff0000, 2'h0, "lb_rst");
      rdc(20'h13000, 32'h0, 2'h2, "unmapped");
      wr(20'h13004, 32'hffffffff, 2'h2);
   endtask
   task automatic t_pll;
      wr(`SPDL_IRQ_MASK, 32'h10, 2'h0);
      wr(`SPDL_PLL_CFG_A1, 32'hffffffff, 2'h0);
      rdc(`SPDL_PLL_CFG_A0, 32'h002fffff, 2'h0, "pll_ro");
      chk(pll_mult_factor, 8'd38, "factor");
      pll_coarse_multiplier <= 3'h0;
      wr(`SPDL_PLL_CFG_A0, 32'h002000c0, 2'h0);
      chk(pll_mult_factor, 8'd14, "factor2");
      chk(irq, 1, "irq_on");
      wr(`SPDL_IRQ_MASK, 32'h0, 2'h0);
      chk(irq, 0, "irq_mask");
      wr(`SPDL_IRQ_MASK, 32'h10, 2'h0);
      wr(`SPDL_IRQ_STAT, 32'h10, 2'h0);
      chk(irq, 0, "irq_clr");
      // Change the fine field with the PLL running: flagged in bit 5
      serdes_in_reset <= 1'b0;
      pll_enabled <= 1'b1;
      wr(`SPDL_PLL_CFG_A0, 32'h00200000, 2'h0);
      rdc(`SPDL_IRQ_STAT, 32'h20, 2'h0, "chg_flag");
      wr(`SPDL_IRQ_STAT, 32'h20, 2'h0);
      // Back to reset so later PLL settings change legally
      serdes_in_reset <= 1'b1;
      pll_enabled <= 1'b0;
   endtask
   task automatic t_loop;
      wr(`SPDL_LB_CLK_A0, 32'h80010300, 2'h0);
      wr(`SPDL_LB_CLK_A1, 32'h80010100, 2'h0);
      chk(equip_loopback, 4'h7, "equip");
      rdc(`SPDL_LB_CLK_A0, 32'h80010300, 2'h0, "lb_a0");
      rdc(`SPDL_LB_CLK_A1, 32'h80010100, 2'h0, "lb_a1");
      chk(silence_timer_enable, 1, "timer_en");
      // Globals written through the second alias show through the first
      wr(`SPDL_LB_CLK_A1, 32'h8001a500, 2'h0);
      chk(line_loopback, 4'ha, "line_lb");
      chk(mac_mode, 1, "mac_mode");
      rdc(`SPDL_LB_CLK_A0, 32'h8001a700, 2'h0, "lb_glob");
   endtask
   task automatic t_dead;
      pkt_valid <= 4'hf;
      mute <= 4'hf;
      repeat (6) @(negedge core_clk);
      chk(port_dead, 0, "early");
      repeat (6) @(negedge core_clk);
      chk(port_dead, 4'hf, "dead");
      chk(pkt_drop, 4'hf, "drop");
      chk(pkt_admit, 0, "admit");
      @(posedge core_clk);
      rdc(`SPDL_IRQ_STAT, 32'hf, 2'h0, "stat");
      mute <= 4'h0;
      repeat (3) @(negedge core_clk);
      chk(pkt_admit, 4'hf, "admit2");
      @(posedge core_clk);
   endtask
   task automatic t_off;
      wr(`SPDL_LB_CLK_A0, 32'h80000000, 2'h0);
      mute <= 4'hf;
      repeat (20) @(negedge core_clk);
      chk(port_dead, 0, "thresh0");
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   initial begin
      repeat (5000) @(posedge core_clk);
      mismatches++;
      tally_and_finish;
   end
   initial begin
      rst_b = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready} = 2'h0;
      s_axi_awaddr = 20'h0;
      s_axi_araddr = 20'h0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hf;
      serdes_in_reset = 1'b1;
      pll_enabled = 1'b0;
      pll_coarse_multiplier = 3'h3;
      link_powered = 4'hf;
      pkt_valid = 4'h0;
      mute = 4'h0;
      repeat (6) @(posedge core_clk);
      rst_b <= 1'b1;
      @(posedge core_clk);
      t_reset;
      t_pll;
      t_loop;
      t_dead;
      t_off;
      tally_and_finish;
   end
endmodule
bind spdl_top spdl_properties #(.CW(CW), .TICK_SHIFT(TICK_SHIFT))
   spdl_properties_inst (.core_clk(core_clk), .rst_b(rst_b),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .pll_coarse_multiplier(pll_coarse_multiplier),
      .link_powered(link_powered), .link_silence(link_silence),
      .link_partner_ok(link_partner_ok), .pkt_valid(pkt_valid),
      .pkt_admit(pkt_admit), .pkt_drop(pkt_drop), .tx_flush(tx_flush),
      .port_dead(port_dead), .ref_divider_select(ref_divider_select),
      .pll_fine_multiplier(pll_fine_multiplier),
      .pll_mult_factor(pll_mult_factor),
      .silence_timer_enable(silence_timer_enable),
      .silence_timer_reload(silence_timer_reload));
`default_nettype wire
